// >>> rtl/ccr_top.sv
// Calendar clock configuration register with value window, over AXI4-Lite.
// Assumes tick is one pulse per crystal period, synchronous to aclk.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module ccr_top
    import ccr_pkg::*;
(
    input wire logic aclk,              // Bus clock, 10 MHz
    input wire logic aresetn,           // Synchronous reset, active low
    input wire logic power_on_reset,    // High when the reset is a power-on reset
    input wire logic tick,              // Crystal pulse enable
    input wire logic [31:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid,     // Write address valid
    output logic s_axi_awready,         // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid,      // Write data valid
    output logic s_axi_wready,          // Write data ready
    output logic [1:0] s_axi_bresp,     // Write response
    output logic s_axi_bvalid,          // Write response valid
    input wire logic s_axi_bready,      // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid,     // Read address valid
    output logic s_axi_arready,         // Read address ready
    output logic [31:0] s_axi_rdata,    // Read data
    output logic [1:0] s_axi_rresp,     // Read response
    output logic s_axi_rvalid,          // Read data valid
    input wire logic s_axi_rready,      // Read data ready
    output logic clock_out,             // Seconds clock output pin
    output logic clock_out_oe           // Output enable of the clock pin
);

    logic module_on_bit;
    logic value_write_unlock;
    logic clock_output_enable;
    logic [1:0] value_window_pointer;
    logic [1:0] next_ptr;
    logic [7:0] cal;
    logic was_power_on;
    logic [7:0] tv [0:7];
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have;
    logic w_have;
    logic do_write;
    logic do_read;
    logic win_write_hi;
    logic win_step;
    logic clear_half;
    logic sec_pulse;
    logic half_second_flag;
    logic rollover_sync_flag;
    logic [2:0] ripple;
    logic [15:0] cfg_read;
    logic [15:0] rst_cfg;

    function automatic logic [7:0] ccr_idx(input logic [31:0] addr);
        ccr_idx = addr[7:0] & 8'hFC;
    endfunction : ccr_idx

    // Slot of one byte of the selected time pair; the high byte sits above the low one.
    function automatic logic [2:0] win_slot(input logic [1:0] ptr, input logic high);
        win_slot = {ptr, high};
    endfunction : win_slot

    assign do_write = aw_have && w_have && !s_axi_bvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign win_write_hi = do_write && ccr_idx(awaddr_q) == CCR_OFF_VAL && wstrb_q[1];
    // A read of the window steps the pointer whichever byte software wanted.
    assign win_step = win_write_hi || (do_read && ccr_idx(s_axi_araddr) == CCR_OFF_VAL);
    // Restarting the second is a time write, so it needs the write lock open.
    assign clear_half = do_write && ccr_idx(awaddr_q) == CCR_OFF_MINUTES_SECONDS_REG && wstrb_q[0] && value_write_unlock;
    assign rollover_sync_flag = ripple != 3'h0;
    assign cfg_read = {module_on_bit, 1'b0, value_write_unlock, rollover_sync_flag,
                       half_second_flag, clock_output_enable, value_window_pointer, cal};
    // A power-on reset clears the register; any other reset keeps the writable fields.
    assign rst_cfg = power_on_reset ? CCR_RST_POWER : (cfg_read & CCR_RST_OTHER_MASK);

    ccr_ptr_step u_ptr (
        .ptr(value_window_pointer),
        .step(win_step),
        .next_ptr(next_ptr)
    );

    ccr_timebase u_tb (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(module_on_bit),
        .tick(tick),
        .cal(cal),
        .clear_half(clear_half),
        .sec_pulse(sec_pulse),
        .half(half_second_flag)
    );

    // Write address and data are taken in either order and held until the response.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awaddr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CCR_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped offsets finish the handshake and answer with an error.
                if (ccr_idx(awaddr_q) > CCR_OFF_RESET_KIND)
                    s_axi_bresp <= CCR_RESP_SLVERR;
                else
                    s_axi_bresp <= CCR_RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            // Readies stay low while a write is held or its response is pending.
            s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !do_write;
            s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !do_write;
        end
    end

    // Kind of reset is caught at the release of reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            was_power_on <= power_on_reset;
    end

    // Configuration register fields.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            module_on_bit <= rst_cfg[CCR_BIT_ON];
            value_write_unlock <= rst_cfg[CCR_BIT_UNLOCK];
            clock_output_enable <= rst_cfg[CCR_BIT_OE];
            cal <= rst_cfg[7:0];
            value_window_pointer <= rst_cfg[CCR_PTR_LO +: 2];
        end
        else
        begin
            value_window_pointer <= next_ptr;
            if (do_write && ccr_idx(awaddr_q) == CCR_OFF_CFG)
            begin
                if (wstrb_q[1])
                begin
                    if (value_write_unlock)
                        module_on_bit <= wdata_q[CCR_BIT_ON];
                    value_write_unlock <= wdata_q[CCR_BIT_UNLOCK];
                    clock_output_enable <= wdata_q[CCR_BIT_OE];
                    value_window_pointer <= wdata_q[CCR_PTR_LO +: 2];
                end
                if (wstrb_q[0])
                    cal <= wdata_q[7:0];
            end
        end
    end

    // Time values held as byte pairs per pointer; the counter tree itself lives elsewhere.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < 8; i++)
                tv[i] <= 8'h00;
        end
        else
        begin
            // Only the seconds byte advances here; carries into minutes belong to the counter tree.
            if (sec_pulse && module_on_bit)
            begin
                tv[0] <= (tv[0] == 8'h59) ? 8'h00 : ((tv[0][3:0] == 4'h9) ? tv[0] + 8'h07 : tv[0] + 8'h01);
            end
            if (do_write && value_write_unlock)
            begin
                if (ccr_idx(awaddr_q) == CCR_OFF_VAL)
                begin
                    if (wstrb_q[0])
                        tv[win_slot(value_window_pointer, 1'b0)] <= wdata_q[7:0];
                    if (wstrb_q[1] && value_window_pointer != CCR_PTR_YEAR)
                        tv[win_slot(value_window_pointer, 1'b1)] <= wdata_q[15:8];
                end
                else if (ccr_idx(awaddr_q) == CCR_OFF_MINUTES_SECONDS_REG)
                begin
                    if (wstrb_q[0])
                        tv[0] <= wdata_q[7:0];
                    if (wstrb_q[1])
                        tv[1] <= wdata_q[15:8];
                end
            end
        end
    end

    // The sync flag stays up for a few cycles after each counted second, while the carry ripples.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ripple <= 3'h0;
        else if (sec_pulse && module_on_bit)
            ripple <= 3'h4;
        else if (ripple != 3'h0)
            ripple <= ripple - 3'h1;
    end

    // Read channel: one read at a time, answered one cycle after the address is taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= CCR_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !do_read;
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= CCR_RESP_OKAY;
                if (ccr_idx(s_axi_araddr) == CCR_OFF_CFG)
                    s_axi_rdata <= {16'h0000, cfg_read};
                else if (ccr_idx(s_axi_araddr) == CCR_OFF_VAL)
                    // The reserved high byte of the year pair reads zero.
                    s_axi_rdata <= {16'h0000,
                        (value_window_pointer == CCR_PTR_YEAR) ? 8'h00 : tv[win_slot(value_window_pointer, 1'b1)],
                        tv[win_slot(value_window_pointer, 1'b0)]};
                else if (ccr_idx(s_axi_araddr) == CCR_OFF_MINUTES_SECONDS_REG)
                    s_axi_rdata <= {16'h0000, tv[1], tv[0]};
                else if (ccr_idx(s_axi_araddr) == CCR_OFF_RESET_KIND)
                    s_axi_rdata <= {31'h00000000, was_power_on};
                else
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= CCR_RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clock_out <= 1'b0;
            clock_out_oe <= 1'b0;
        end
        else
        begin
            // The pin shows the half-second flag, a square wave of one period per second.
            clock_out <= half_second_flag;
            clock_out_oe <= clock_output_enable;
        end
    end

endmodule : ccr_top

// >>> rtl/ccr_pkg.sv
// Package for the calendar clock configuration register block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package ccr_pkg;

    // Register byte offsets.
    localparam logic [7:0] CCR_OFF_CFG = 8'h00;
    localparam logic [7:0] CCR_OFF_VAL = 8'h04;
    localparam logic [7:0] CCR_OFF_MINUTES_SECONDS_REG = 8'h08;
    localparam logic [7:0] CCR_OFF_RESET_KIND = 8'h0C;

    // Field positions inside the configuration register.
    localparam int CCR_BIT_ON = 15;
    localparam int CCR_BIT_UNLOCK = 13;
    localparam int CCR_BIT_SYNC = 12;
    localparam int CCR_BIT_HALF = 11;
    localparam int CCR_BIT_OE = 10;
    localparam int CCR_PTR_LO = 8;

    // Reset value of the configuration register for a power-on reset, and the mask of fields that any other reset keeps.
    localparam logic [15:0] CCR_RST_POWER = 16'h0000;
    localparam logic [15:0] CCR_RST_OTHER_MASK = 16'hA7FF;

    // Timing: 10 MHz bus clock, the tick input marks one crystal pulse.
    localparam int CCR_CLK_HZ = 10000000;
    localparam logic [14:0] CCR_PULSES_PER_SEC = 15'h7FFF;
    localparam logic [14:0] CCR_HALF_PULSE = 15'h4000;
    localparam logic [5:0] CCR_SEC_PER_MIN = 6'h3C;
    localparam logic [9:0] CCR_CAL_STEP = 10'h004;

    // Window pointer selections.
    localparam logic [1:0] CCR_PTR_MINUTES_SECONDS_REG = 2'h0;
    localparam logic [1:0] CCR_PTR_WDHR = 2'h1;
    localparam logic [1:0] CCR_PTR_MONDAY = 2'h2;
    localparam logic [1:0] CCR_PTR_YEAR = 2'h3;

    localparam logic [1:0] CCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCR_RESP_SLVERR = 2'h2;

endpackage : ccr_pkg

// >>> rtl/ccr_ptr_step.sv
// Window pointer stepping logic.
// Assumes the caller flags each read and each high-byte write of the value window in one cycle.
`timescale 1ns/1ns
module ccr_ptr_step
    import ccr_pkg::*;
(
    input wire logic [1:0] ptr,     // Current pointer
    input wire logic step,          // Access that steps the pointer
    output logic [1:0] next_ptr     // Pointer after this cycle
);

    always_comb
    begin
        if (step && ptr != CCR_PTR_MINUTES_SECONDS_REG)
            next_ptr = ptr - 2'h1;
        else
            next_ptr = ptr;
    end

endmodule : ccr_ptr_step

// >>> rtl/ccr_timebase.sv
// Second timebase with drift calibration and half-second status.
// Assumes tick is a one-cycle pulse per crystal period in the bus clock domain.
`timescale 1ns/1ns
module ccr_timebase
    import ccr_pkg::*;
(
    input wire logic aclk,          // Bus clock
    input wire logic aresetn,       // Synchronous reset, active low
    input wire logic run,           // Module switched on
    input wire logic tick,          // Crystal pulse enable
    input wire logic [7:0] cal,     // Signed calibration value
    input wire logic clear_half,    // Restart the second
    output logic sec_pulse,         // One-cycle pulse per second
    output logic half                // Second half of the second
);

    logic [14:0] pulse_cnt;
    logic [5:0] sec_cnt;
    logic [9:0] skip;
    logic [9:0] cal_mag;
    logic [9:0] cal_pulses;
    logic minute_end;

    // Magnitude of the signed calibration; the most negative value gives 128 steps.
    assign cal_mag = cal[7] ? (10'h000 - {2'h3, cal}) : {2'h0, cal};
    assign cal_pulses = 10'(cal_mag * CCR_CAL_STEP);
    assign minute_end = sec_pulse && sec_cnt == CCR_SEC_PER_MIN - 6'h1;

    // Second counter; calibration adds or removes pulses once per minute.
    always_ff @(posedge aclk)
    begin
        sec_pulse <= 1'b0;
        if (!aresetn)
        begin
            pulse_cnt <= 15'h0000;
            skip <= 10'h000;
        end
        else if (clear_half)
            pulse_cnt <= 15'h0000;
        else if (run && tick)
        begin
            // Positive calibration adds pulses by counting two at once; negative drops pulses.
            if (skip != 10'h000 && !cal[7])
            begin
                skip <= skip - 10'h001;
                if (pulse_cnt == CCR_PULSES_PER_SEC)
                begin
                    pulse_cnt <= 15'h0000;
                    sec_pulse <= 1'b1;
                end
                else
                    pulse_cnt <= pulse_cnt + 15'h0001 + 15'(pulse_cnt != CCR_PULSES_PER_SEC - 15'h1);
            end
            else if (skip != 10'h000)
                skip <= skip - 10'h001;
            else if (pulse_cnt == CCR_PULSES_PER_SEC)
            begin
                pulse_cnt <= 15'h0000;
                sec_pulse <= 1'b1;
            end
            else
                pulse_cnt <= pulse_cnt + 15'h0001;
        end
        if (aresetn && minute_end)
            skip <= cal_pulses;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sec_cnt <= 6'h00;
        else if (sec_pulse)
            sec_cnt <= (sec_cnt == CCR_SEC_PER_MIN - 6'h1) ? 6'h00 : sec_cnt + 6'h01;
    end

    assign half = pulse_cnt >= CCR_HALF_PULSE;

endmodule : ccr_timebase

// >>> verif/ccr_top_chk.sv
// Bus and pin checker for the calendar clock configuration register block.
// Assumes it is bound to ccr_top and sees only that module's ports.
`timescale 1ns/1ns
module ccr_top_chk
    import ccr_pkg::*;
(
    input wire logic aclk, // Bus clock
    input wire logic aresetn, // Reset, active low
    input wire logic [31:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic clock_out_oe // Clock pin enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic aw_w;
    logic ar_t;
    logic cfg_w;
    assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign ar_t = s_axi_arvalid && s_axi_arready;
    assign cfg_w = aw_w && s_axi_awaddr == 32'h00000000 && s_axi_wstrb[1];
    a_write_answer: assert property (aw_w |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (ar_t |=> s_axi_rvalid ##0 !s_axi_arready)
        else $error("read answer missing");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_unmapped_read: assert property (ar_t && s_axi_araddr[7:2] > 6'h03
        |=> s_axi_rresp == CCR_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_unmapped_write: assert property (aw_w && s_axi_awaddr[7:2] > 6'h03 |-> ##2 s_axi_bresp == CCR_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_cfg_unused: assert property (ar_t && s_axi_araddr == 32'h00000000
        |=> s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[14])
        else $error("unused configuration bits set");
    a_oe_set: assert property (cfg_w && s_axi_wdata[CCR_BIT_OE] |-> ##[1:3] clock_out_oe)
        else $error("clock output not enabled");
    a_oe_clear: assert property (cfg_w && !s_axi_wdata[CCR_BIT_OE] |-> ##[1:3] !clock_out_oe)
        else $error("clock output not disabled");
endmodule : ccr_top_chk

bind ccr_top ccr_top_chk i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_out_oe);

// >>> verif/ccr_top_tb.sv
// Self-checking bench for the calendar clock configuration register block.
// Assumes the register map and bus timing of ccr_top and a tick held high.
`timescale 1ns/1ns
module ccr_top_tb;
    import ccr_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic power_on_reset = 1'h1;
    logic tick = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clock_out, clock_out_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int mismatches = 0;
    int checks_done = 0;
    logic seen = 1'h0;
    logic [15:0] vals [4] = '{16'h0024, 16'h0115, 16'h0312, 16'h4530};

    ccr_top i_dut (.aclk(aclk), .aresetn(aresetn), .power_on_reset(power_on_reset), .tick(tick),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .clock_out(clock_out),
        .clock_out_oe(clock_out_oe));

    always #50 aclk = ~aclk;

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rst(input logic kind);
        aresetn <= 1'h0;
        power_on_reset <= kind;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
    endtask : rst

    // Address and data are offered together and each is released once taken.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'h0;
        wd = 1'h0;
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= {16'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e, input logic [1:0] er);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk($sformatf("rdata %h", a), {16'h0, e}, s_axi_rdata & {16'hFFFF, m});
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
        @(posedge aclk);
    endtask : rd

    initial
    begin
        repeat (100000) @(posedge aclk);
        mismatches++;
        results();
    end

    initial
    begin
        rst(1'h1);
        rd(8'h00, 16'hFFFF, 16'h0000, CCR_RESP_OKAY);
        rd(8'h0C, 16'h0001, 16'h0001, CCR_RESP_OKAY);
        rst(1'h0);
        rd(8'h0C, 16'h0001, 16'h0000, CCR_RESP_OKAY);
        wr(8'h10, 16'h0000, 4'hF, CCR_RESP_SLVERR);
        rd(8'h10, 16'hFFFF, 16'h0000, CCR_RESP_SLVERR);
        wr(8'h00, 16'h2000, 4'h3, CCR_RESP_OKAY);
        wr(8'h00, 16'hBC80, 4'h3, CCR_RESP_OKAY);
        rd(8'h00, 16'hFFFF, 16'hA480, CCR_RESP_OKAY);
        chk("clock_out_oe", 32'h1, {31'h0, clock_out_oe});
        wr(8'h00, 16'h2300, 4'h3, CCR_RESP_OKAY);
        chk("clock_out_oe", 32'h0, {31'h0, clock_out_oe});
        // The pointer starts at three and must stop at zero after the fourth write.
        for (int i = 0; i < 4; i++)
            wr(8'h04, vals[i], 4'h3, CCR_RESP_OKAY);
        rd(8'h00, 16'h0300, 16'h0000, CCR_RESP_OKAY);
        wr(8'h00, 16'h2300, 4'h3, CCR_RESP_OKAY);
        for (int i = 0; i < 4; i++)
            rd(8'h04, i == 0 ? 16'h00FF : 16'hFFFF, vals[i], CCR_RESP_OKAY);
        rd(8'h00, 16'h0300, 16'h0000, CCR_RESP_OKAY);
        wr(8'h00, 16'h2200, 4'h3, CCR_RESP_OKAY);
        wr(8'h04, 16'h0016, 4'h1, CCR_RESP_OKAY);
        rd(8'h00, 16'h0300, 16'h0200, CCR_RESP_OKAY);
        rd(8'h04, 16'hFFFF, 16'h0116, CCR_RESP_OKAY);
        wr(8'h00, 16'h0000, 4'h3, CCR_RESP_OKAY);
        wr(8'h04, 16'h1111, 4'h3, CCR_RESP_OKAY);
        rd(8'h04, 16'hFFFF, 16'h4530, CCR_RESP_OKAY);
        wr(8'h00, 16'h8000, 4'h3, CCR_RESP_OKAY);
        rd(8'h00, 16'h8000, 16'h0000, CCR_RESP_OKAY);
        wr(8'h00, 16'h2000, 4'h3, CCR_RESP_OKAY);
        wr(8'h00, 16'hA400, 4'h3, CCR_RESP_OKAY);
        wr(8'h08, 16'h4530, 4'h3, CCR_RESP_OKAY);
        tick <= 1'h1;
        repeat (5000) @(posedge aclk);
        rd(8'h00, 16'h0800, 16'h0000, CCR_RESP_OKAY);
        repeat (15000) @(posedge aclk);
        rd(8'h00, 16'h0800, 16'h0800, CCR_RESP_OKAY);
        chk("clock_out", 32'h1, {31'h0, clock_out});
        wr(8'h08, 16'h0030, 4'h1, CCR_RESP_OKAY);
        rd(8'h00, 16'h0800, 16'h0000, CCR_RESP_OKAY);
        repeat (32000) @(posedge aclk);
        // Poll around the end of the second until the rollover sync flag is seen.
        for (int i = 0; i < 600 && !seen; i++)
        begin
            rd(8'h00, 16'h8000, 16'h8000, CCR_RESP_OKAY);
            seen = s_axi_rdata[CCR_BIT_SYNC];
        end
        chk("rollover_sync_flag", 32'h1, {31'h0, seen});
        // Time read during a ripple is read twice and each read is checked against 4531.
        rd(8'h08, 16'hFFFF, 16'h4531, CCR_RESP_OKAY);
        rd(8'h08, 16'hFFFF, 16'h4531, CCR_RESP_OKAY);
        wr(8'h00, 16'h2000, 4'h3, CCR_RESP_OKAY);
        repeat (34000) @(posedge aclk);
        rd(8'h08, 16'hFFFF, 16'h4531, CCR_RESP_OKAY);
        wr(8'h00, 16'h2655, 4'h3, CCR_RESP_OKAY);
        rst(1'h0);
        rd(8'h00, 16'hFFFF, 16'h2655 & CCR_RST_OTHER_MASK, CCR_RESP_OKAY);
        rst(1'h1);
        rd(8'h00, 16'hFFFF, CCR_RST_POWER, CCR_RESP_OKAY);
        results();
    end
endmodule : ccr_top_tb
